// >>> hw/acsc_pkg.sv
// constants for the accelerometer state and sampling control
// assumes a 100 MHz ref_clk and a host command link clocked at 8 MHz

package acsc_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;                 // ref_clk period
   localparam int WAKE_TIME_NS   = 10000;              // longest wake
   localparam int WAKE_CYCLES    = WAKE_TIME_NS / CLK_PERIOD_NS;
   localparam int ODR_BASE_NS    = 500000;             // 1 / 2000 Hz
   localparam int ODR_BASE_CYCLES = ODR_BASE_NS / CLK_PERIOD_NS;
   localparam logic [11:0] RATE_MAX = 12'hf9f;         // 4000 bases = 2 s
   localparam logic [11:0] RATE_RST = 12'h013;         // 100 Hz

   // ----------------------------------------------------------------
   // register indices on the host link
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_MODE   = 4'h0;
   localparam logic [3:0] REG_RANGE  = 4'h1;
   localparam logic [3:0] REG_RATE   = 4'h2;
   localparam logic [3:0] REG_OFS_X  = 4'h3;           // then y, z
   localparam logic [3:0] REG_GAIN_X = 4'h6;           // then y, z
   localparam logic [3:0] REG_RES_X  = 4'ha;           // then y, z

   // mode register fields
   localparam int MODE_STATE_LSB = 0;                  // state[1:0]
   localparam int MODE_SRST_BIT  = 7;                  // soft reset
   localparam logic [1:0] MODE_IDLE   = 2'h0;
   localparam logic [1:0] MODE_ACTIVE = 2'h1;

   // ----------------------------------------------------------------
   // span codes, sensitivities, correction
   // ----------------------------------------------------------------
   localparam logic [2:0] RANGE_2G  = 3'h0;
   localparam logic [2:0] RANGE_4G  = 3'h1;
   localparam logic [2:0] RANGE_8G  = 3'h2;
   localparam logic [2:0] RANGE_16G = 3'h3;
   localparam logic [2:0] RANGE_12G = 3'h4;
   localparam logic [16:0] SENS_2G  = 17'h04000;       // 16384
   localparam logic [16:0] SENS_4G  = 17'h02000;       // 8192
   localparam logic [16:0] SENS_8G  = 17'h01000;       // 4096
   localparam logic [16:0] SENS_12G = 17'h00aaa;       // 2730
   localparam logic [16:0] SENS_16G = 17'h00800;       // 2048
   localparam int SENS_SHIFT = 14;                     // raw is 1/16384 g
   localparam int GAIN_FRAC  = 15;
   localparam logic [15:0] GAIN_RST = 16'h8000;        // unity gain
   localparam logic [15:0] SAT_POS  = 16'h7fff;
   localparam logic [15:0] SAT_NEG  = 16'h8000;

   // operating states
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_WAKING = 2'b10
   } acsc_state_e;

endpackage

// >>> hw/acsc_axis_conv.sv
// one axis: span scaling, gain and offset, saturation
// assumes raw input in units of 1/16384 g, all inputs stable per cycle
`timescale 1ns/10ps
`default_nettype none

module acsc_axis_conv
   import acsc_pkg::*;
#(
   parameter int RAW_W = 20
) (
   input  wire logic signed [RAW_W-1:0] raw,
   input  wire logic        [2:0]       range_sel,
   input  wire logic signed [15:0]      offset,
   input  wire logic        [15:0]      gain,
   output logic             [15:0]      result
);

   // ----------------------------------------------------------------
   // arithmetic
   // ----------------------------------------------------------------
   logic signed [16:0] sens;     // counts per g, as signed
   logic signed [39:0] prod;     // raw times sensitivity
   logic signed [39:0] scaled;   // counts at chosen span
   logic signed [39:0] gained;   // after gain
   logic signed [39:0] summed;   // after offset

   // sensitivity table by span
   always_comb begin
      case (range_sel)
         RANGE_4G:  sens = SENS_4G;
         RANGE_8G:  sens = SENS_8G;
         RANGE_12G: sens = SENS_12G;
         RANGE_16G: sens = SENS_16G;
         default:   sens = SENS_2G;
      endcase
   end

   // scale, correct, clamp
   always_comb begin
      prod   = 40'(raw) * 40'(sens);
      scaled = prod >>> SENS_SHIFT;
      gained = (scaled * 40'(signed'({1'b0, gain}))) >>> GAIN_FRAC;
      summed = gained + 40'(offset);
      if (summed > 40'sh0000007fff) begin
         result = SAT_POS;
      end else if (summed < -40'sh0000008000) begin
         result = SAT_NEG;
      end else begin
         result = summed[15:0];
      end
   end

endmodule

`default_nettype wire

// >>> hw/acsc_top.sv
// operating state, sample timing and host register access
// assumes host drives link_* on link_clk falling edges, period >= 125 ns,
// and raw_* come from the sensor front end on ref_clk
`timescale 1ns/10ps
`default_nettype none

module acsc_top
   import acsc_pkg::*;
#(
   parameter int RAW_W       = 20,
   parameter int TICK_CYCLES = ODR_BASE_CYCLES   // shorten in simulation
) (
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic                    link_clk,
   input  wire logic                    link_wr,
   input  wire logic                    link_rd,
   input  wire logic        [3:0]       link_addr,
   input  wire logic        [15:0]      link_wdata,
   input  wire logic signed [RAW_W-1:0] raw_x,
   input  wire logic signed [RAW_W-1:0] raw_y,
   input  wire logic signed [RAW_W-1:0] raw_z,
   output logic             [15:0]      link_rdata,
   output logic                         write_refused,
   output logic             [1:0]       op_state,
   output logic                         clk_run,
   output logic                         sample_valid,
   output logic             [15:0]      x_axis_result,
   output logic             [15:0]      y_axis_result,
   output logic             [15:0]      z_axis_result
);

   // ----------------------------------------------------------------
   // link synchroniser and edge finder
   // ----------------------------------------------------------------
   logic [22:0] lnk_s1;          // first stage, read by lnk_s2 only
   logic [22:0] lnk_s2;          // settled link bundle
   logic        lclk_d;          // delayed settled link clock
   logic        edge_evt;        // link clock rising edge
   logic        wr_evt;          // host write this cycle
   logic        rd_evt;          // host read this cycle
   logic [3:0]  cmd_idx;         // register index
   logic [15:0] wr_data;         // write data
   logic [1:0]  wr_state;        // mode state field
   logic [2:0]  wr_range;        // range field
   logic        sw_rst;          // soft reset pulse
   logic        rst_all;         // pin or soft reset

   // two flops on every link pin
   always_ff @(posedge ref_clk) begin
      lnk_s1 <= {link_clk, link_wr, link_rd, link_addr, link_wdata};
      lnk_s2 <= lnk_s1;
      lclk_d <= lnk_s2[22];
   end

   assign edge_evt = lnk_s2[22] & ~lclk_d;
   assign wr_evt   = edge_evt & lnk_s2[21];
   assign rd_evt   = edge_evt & lnk_s2[20];
   assign cmd_idx  = lnk_s2[19:16];
   assign wr_data  = lnk_s2[15:0];
   assign wr_state = wr_data[MODE_STATE_LSB+1:MODE_STATE_LSB];
   assign wr_range = wr_data[2:0];
   assign rst_all  = rst | sw_rst;

   // ----------------------------------------------------------------
   // operating state
   // ----------------------------------------------------------------
   acsc_state_e state;           // current state
   acsc_state_e next_state;      // state after this edge
   logic [15:0] wake_cnt;        // settle count while waking
   logic        mode_wr;         // write aimed at mode register

   assign mode_wr = wr_evt && (cmd_idx == REG_MODE);

   // state changes only on a mode write or wake completion
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (mode_wr && wr_state == MODE_ACTIVE) begin
               next_state = ST_WAKING;
            end
         end
         ST_WAKING: begin
            if (mode_wr && wr_state == MODE_IDLE) begin
               next_state = ST_IDLE;
            end else if (wake_cnt == 16'(WAKE_CYCLES - 1)) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (mode_wr && wr_state == MODE_IDLE) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // state register, idle from reset
   always_ff @(posedge ref_clk) begin
      if (rst_all) begin
         state   <= ST_IDLE;
         clk_run <= 1'b0;
      end else begin
         state   <= next_state;
         clk_run <= (next_state != ST_IDLE);
      end
   end

   // wake settle counter
   always_ff @(posedge ref_clk) begin
      if (rst_all || state != ST_WAKING) begin
         wake_cnt <= 16'h0000;
      end else begin
         wake_cnt <= wake_cnt + 16'h0001;
      end
   end

   // soft reset honoured only while active
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sw_rst <= 1'b0;
      end else begin
         sw_rst <= mode_wr && wr_data[MODE_SRST_BIT]
                   && (state == ST_ACTIVE);
      end
   end

   // ----------------------------------------------------------------
   // settings registers
   // ----------------------------------------------------------------
   logic [2:0]         range_reg;    // span code
   logic [11:0]        rate_reg;     // period in 0.5 ms bases, minus one
   logic signed [15:0] ofs [3];      // per-axis offset
   logic [15:0]        gain [3];     // per-axis gain
   logic               set_ok;       // settings write accepted

   assign set_ok = wr_evt && (state == ST_IDLE);

   // refused write flag, one cycle
   always_ff @(posedge ref_clk) begin
      if (rst_all) begin
         write_refused <= 1'b0;
      end else begin
         write_refused <= wr_evt && (state != ST_IDLE)
                          && (cmd_idx != REG_MODE);
      end
   end

   // range and rate, only in idle
   always_ff @(posedge ref_clk) begin
      if (rst_all) begin
         range_reg <= RANGE_2G;
         rate_reg  <= RATE_RST;
      end else if (set_ok && cmd_idx == REG_RANGE) begin
         range_reg <= wr_range;
      end else if (set_ok && cmd_idx == REG_RATE) begin
         rate_reg  <= (wr_data[11:0] > RATE_MAX) ? RATE_MAX
                      : wr_data[11:0];
      end
   end

   // ----------------------------------------------------------------
   // per-axis correction and conversion
   // ----------------------------------------------------------------
   logic signed [RAW_W-1:0] raw_ax [3];   // raw inputs by axis
   logic        [15:0]      conv   [3];   // converted words
   logic        [15:0]      res    [3];   // held results

   assign raw_ax[0] = raw_x;
   assign raw_ax[1] = raw_y;
   assign raw_ax[2] = raw_z;

   genvar ax;
   generate
      for (ax = 0; ax < 3; ax++) begin : g_axis
         // offset and gain, writable in idle only
         always_ff @(posedge ref_clk) begin
            if (rst_all) begin
               ofs[ax]  <= 16'sh0000;
               gain[ax] <= GAIN_RST;
            end else if (set_ok && cmd_idx == REG_OFS_X + 4'(ax)) begin
               ofs[ax]  <= wr_data;
            end else if (set_ok && cmd_idx == REG_GAIN_X + 4'(ax)) begin
               gain[ax] <= wr_data;
            end
         end

         acsc_axis_conv #(
            .RAW_W     (RAW_W)
         ) u_conv (
            .raw       (raw_ax[ax]),
            .range_sel (range_reg),
            .offset    (ofs[ax]),
            .gain      (gain[ax]),
            .result    (conv[ax])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // sample timing
   // ----------------------------------------------------------------
   logic [31:0] tick_cnt;        // cycles within one base period
   logic [11:0] base_cnt;        // base periods within one sample
   logic        first;           // first sample still owed
   logic        sample_now;      // take a sample this edge

   assign sample_now = (state == ST_ACTIVE) && (first ||
      (tick_cnt == 32'(TICK_CYCLES - 1) && base_cnt == rate_reg));

   // counters run only while active
   always_ff @(posedge ref_clk) begin
      if (rst_all || state != ST_ACTIVE) begin
         tick_cnt <= 32'h0000_0000;
         base_cnt <= 12'h000;
         first    <= 1'b1;
      end else if (first) begin
         // hold counters at zero so the first period is a full one
         first <= 1'b0;
      end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
         tick_cnt <= 32'h0000_0000;
         base_cnt <= (base_cnt == rate_reg) ? 12'h000
                     : base_cnt + 12'h001;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end

   // capture all three axes together
   always_ff @(posedge ref_clk) begin
      if (rst_all) begin
         res[0]       <= 16'h0000;
         res[1]       <= 16'h0000;
         res[2]       <= 16'h0000;
         sample_valid <= 1'b0;
      end else begin
         sample_valid <= sample_now;
         if (sample_now) begin
            res[0] <= conv[0];
            res[1] <= conv[1];
            res[2] <= conv[2];
         end
      end
   end

   assign x_axis_result = res[0];
   assign y_axis_result = res[1];
   assign z_axis_result = res[2];
   assign op_state      = state;

   // ----------------------------------------------------------------
   // host reads, allowed in every state
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst_all) begin
         link_rdata <= 16'h0000;
      end else if (rd_evt) begin
         case (cmd_idx)
            REG_MODE:   link_rdata <= {14'h0000, state};
            REG_RANGE:  link_rdata <= {13'h0000, range_reg};
            REG_RATE:   link_rdata <= {4'h0, rate_reg};
            4'h3:       link_rdata <= ofs[0];
            4'h4:       link_rdata <= ofs[1];
            4'h5:       link_rdata <= ofs[2];
            4'h6:       link_rdata <= gain[0];
            4'h7:       link_rdata <= gain[1];
            4'h8:       link_rdata <= gain[2];
            REG_RES_X:  link_rdata <= res[0];
            4'hb:       link_rdata <= res[1];
            4'hc:       link_rdata <= res[2];
            default:    link_rdata <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_power_up_idle: assert property (@(posedge ref_clk)
      $past(rst) |-> state == ST_IDLE)
      else $error("state not idle after reset");

   a_idle_no_sample: assert property (@(posedge ref_clk)
      disable iff (rst) (state == ST_IDLE) |=> !sample_valid)
      else $error("sample produced in idle");

   a_idle_clock_off: assert property (@(posedge ref_clk)
      disable iff (rst) (state == ST_IDLE) |-> !clk_run)
      else $error("clocking runs in idle");

   a_wake_time_bound: assert property (@(posedge ref_clk)
      disable iff (rst_all) $rose(state == ST_WAKING)
      |-> ##[1:1000] (state != ST_WAKING))
      else $error("wake took longer than 10 us");

   a_no_auto_change: assert property (@(posedge ref_clk)
      disable iff (rst) (state != $past(state)
      && $past(state) != ST_WAKING) |-> ($past(wr_evt) || $past(sw_rst)))
      else $error("state changed without command");

   a_active_blocks_wr: assert property (@(posedge ref_clk)
      disable iff (rst_all) (wr_evt && state != ST_IDLE
      && cmd_idx != REG_MODE) |=> ($stable(range_reg) && $stable(rate_reg)
      && write_refused))
      else $error("write taken while active");

   a_idle_takes_wr: assert property (@(posedge ref_clk)
      disable iff (rst_all) (set_ok && cmd_idx == REG_RANGE)
      |=> range_reg == $past(wr_range))
      else $error("idle range write lost");

   a_mode_wake_cmd: assert property (@(posedge ref_clk)
      disable iff (rst_all) (mode_wr && wr_state == MODE_ACTIVE
      && state == ST_IDLE) |=> state == ST_WAKING)
      else $error("mode 01 did not start wake");

   a_first_sample: assert property (@(posedge ref_clk)
      disable iff (rst_all) $rose(state == ST_ACTIVE) |-> ##1 sample_valid)
      else $error("no sample on entering active");

endmodule

`default_nettype wire

// >>> test/acsc_host_model.sv
// host side of the register link: issues one command per link period
// assumes the bench calls cmd only after reset has been released
`timescale 1ns/10ps
`default_nettype none

module acsc_host_model (
   output var logic        link_clk,
   output var logic        link_wr,
   output var logic        link_rd,
   output var logic [3:0]  link_addr,
   output var logic [15:0] link_wdata
);
   // ------------------------------------------------------------
   // idle lines: clock parked low, strobes off
   // ------------------------------------------------------------
   initial begin
      link_clk = 1'b0;
      link_wr = 1'b0;
      link_rd = 1'b0;
      link_addr = 4'h0;
      link_wdata = 16'h0000;
   end

   // ------------------------------------------------------------
   // one 125 ns link cycle, data steady around the rising edge
   // ------------------------------------------------------------
   task automatic cmd(input logic wr, input logic rd,
                      input logic [3:0] a, input logic [15:0] d);
      link_wr = wr;
      link_rd = rd;
      link_addr = a;
      link_wdata = d;
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
      // released lines show no stale value
      link_wr = 1'b0;
      link_rd = 1'b0;
      link_addr = ~a;
      link_wdata = ~d;
      // leave room for the synchroniser and the answer
      #200;
   endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the state and sampling control block
// assumes the package constants and a 20-cycle sample tick
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import acsc_pkg::*;
   localparam int TICK = 20;             // shortened sample tick
   logic               ref_clk;          // 100 MHz clock
   logic               rst;              // sync reset
   wire logic          link_clk;         // host link clock
   wire logic          link_wr;          // write strobe
   wire logic          link_rd;          // read strobe
   wire logic [3:0]    link_addr;        // register index
   wire logic [15:0]   link_wdata;       // write data
   logic signed [19:0] raw_x, raw_y, raw_z; // front end samples
   logic [15:0]        link_rdata;       // read data
   logic               write_refused;    // refusal pulse
   logic [1:0]         op_state;         // state
   logic               clk_run;          // clocking enable
   logic               sample_valid;     // sample pulse
   logic [15:0]        xr, yr, zr;       // axis results
   int                 n_errors, n_checks, cyc, n_ref;

   acsc_host_model host (.link_clk(link_clk), .link_wr(link_wr),
      .link_rd(link_rd), .link_addr(link_addr), .link_wdata(link_wdata));

   acsc_top #(.RAW_W(20), .TICK_CYCLES(TICK)) uut (.ref_clk(ref_clk),
      .rst(rst), .link_clk(link_clk), .link_wr(link_wr),
      .link_rd(link_rd), .link_addr(link_addr), .link_wdata(link_wdata),
      .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
      .link_rdata(link_rdata), .write_refused(write_refused),
      .op_state(op_state), .clk_run(clk_run),
      .sample_valid(sample_valid), .x_axis_result(xr),
      .y_axis_result(yr), .z_axis_result(zr));

   // ------------------------------------------------------------
   // clock, cycle count, refusal cycle count
   // ------------------------------------------------------------
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (write_refused === 1'b1) begin
         n_ref <= n_ref + 1;
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // bounded wait for a sample pulse, seen just after the edge
   task automatic wait_valid(input int lim);
      int k;
      k = 0;
      do begin
         @(posedge ref_clk);
         #1;
         k++;
      end while (sample_valid !== 1'b1 && k < lim);
      if (sample_valid !== 1'b1) begin
         n_errors++;
         $display("[ERR] %0t no sample pulse", $time);
         report_and_stop();
      end
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      host.cmd(1'b0, 1'b1, a, 16'h0000);
      chk(link_rdata, exp, "read back");
   endtask

   // count sample pulses over n idle cycles
   task automatic quiet(input int n);
      int p;
      p = 0;
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         if (sample_valid !== 1'b0) p++;
      end
      chk(16'(p), 16'h0000, "pulses while idle");
      chk({14'h0, op_state}, 16'h0000, "left idle alone");
   endtask

   task automatic go_idle();
      host.cmd(1'b1, 1'b0, REG_MODE, 16'h0000);
      chk({14'h0, op_state}, 16'h0000, "idle state");
      chk({15'h0, clk_run}, 16'h0000, "clock halted");
   endtask

   task automatic go_active();
      int t0;
      int k;
      t0 = cyc;
      k = 0;
      host.cmd(1'b1, 1'b0, REG_MODE, 16'h0001);
      chk({14'h0, op_state}, 16'h0002, "waking");
      while (op_state !== MODE_ACTIVE && k < 1100) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      if (op_state !== MODE_ACTIVE) begin
         n_errors++;
         $display("[ERR] %0t wake never finished", $time);
         report_and_stop();
      end
      // 10 us wake plus the link synchroniser
      chk(16'(cyc - t0 <= 1030), 16'h0001, "wake time");
      chk({15'h0, clk_run}, 16'h0001, "clock running");
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic s_power_up();
      chk({14'h0, op_state}, 16'h0000, "power-up state");
      quiet(300);
      host.cmd(1'b1, 1'b0, REG_OFS_X, 16'h0005);
      host.cmd(1'b1, 1'b0, REG_GAIN_X, 16'h4000);
      rd_chk(REG_OFS_X, 16'h0005);
      rd_chk(REG_GAIN_X, 16'h4000);
      rd_chk(REG_MODE, 16'h0000);
   endtask

   task automatic s_sampling();
      int t0;
      @(posedge ref_clk);
      raw_x <= 20'sd16384;
      raw_y <= 20'sd100000;
      raw_z <= -20'sd100000;
      go_active();
      wait_valid(50);
      chk(xr, 16'd8197, "gain half plus offset 5");
      chk(yr, SAT_POS, "positive clip");
      chk(zr, SAT_NEG, "negative clip");
      t0 = cyc;
      wait_valid(500);
      chk(16'(cyc - t0), 16'(20 * TICK), "sample period");
      rd_chk(REG_MODE, 16'h0001);
   endtask

   task automatic s_refused();
      int n0;
      n0 = n_ref;
      host.cmd(1'b1, 1'b0, REG_RANGE, 16'h0003);
      chk(16'(n_ref - n0), 16'h0001, "one refusal pulse");
      host.cmd(1'b1, 1'b0, REG_OFS_X, 16'h0077);
      rd_chk(REG_RANGE, 16'h0000);
      rd_chk(REG_OFS_X, 16'h0005);
   endtask

   task automatic s_ranges();
      logic [2:0]  code [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
      logic [15:0] sens [5] = '{16'd16384, 16'd8192, 16'd4096,
                                16'd2730, 16'd2048};
      go_idle();
      quiet(500);
      host.cmd(1'b1, 1'b0, REG_OFS_X, 16'h0000);
      host.cmd(1'b1, 1'b0, REG_GAIN_X, GAIN_RST);
      for (int i = 0; i < 5; i++) begin
         host.cmd(1'b1, 1'b0, REG_RANGE, {13'h0, code[i]});
         rd_chk(REG_RANGE, {13'h0, code[i]});
         go_active();
         wait_valid(50);
         chk(xr, sens[i], "one g at span");
         go_idle();
      end
   endtask

   task automatic s_soft_reset();
      go_active();
      host.cmd(1'b1, 1'b0, REG_MODE, 16'h0081);
      chk({14'h0, op_state}, 16'h0000, "idle after reset");
      rd_chk(REG_RANGE, 16'h0000);
      // reset bit and code 10 in idle must both be ignored
      host.cmd(1'b1, 1'b0, REG_RANGE, 16'h0002);
      host.cmd(1'b1, 1'b0, REG_MODE, 16'h0082);
      chk({14'h0, op_state}, 16'h0000, "code 10 ignored");
      rd_chk(REG_RANGE, 16'h0002);
   endtask

   // rate clamp and a short programmed sample period
   task automatic s_rate();
      int t0;
      host.cmd(1'b1, 1'b0, REG_RATE, 16'hffff);
      rd_chk(REG_RATE, {4'h0, RATE_MAX});
      host.cmd(1'b1, 1'b0, REG_RATE, 16'h0001);
      go_active();
      wait_valid(50);
      t0 = cyc;
      wait_valid(100);
      chk(16'(cyc - t0), 16'(2 * TICK), "fast sample period");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      raw_x = '0;
      raw_y = '0;
      raw_z = '0;
      n_errors = 0;
      n_checks = 0;
      cyc = 0;
      n_ref = 0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
      s_power_up();
      s_sampling();
      s_refused();
      s_ranges();
      s_soft_reset();
      s_rate();
      report_and_stop();
   end
endmodule
`default_nettype wire
